// ---- core/mrc_buf2.sv ----
// Purpose: Small FIFO between the reply builder and the transmitter.
// Assumes: Same clock on both sides.
// Notes:   A stall on the drain side backs up to the builder.
`timescale 1ns/10ps
`default_nettype none
module mrc_buf2 #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 2
) (
    // Clock and reset.
    input  wire logic             clock_i,
    input  wire logic             rst_n_i,
    // Fill side.
    input  wire logic             in_valid_i,
    input  wire logic [WIDTH-1:0] in_data_i,
    output logic                  in_ready_o,
    // Drain side.
    output logic                  out_valid_o,
    output logic      [WIDTH-1:0] out_data_o,
    input  wire logic             out_ready_i
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    logic [WIDTH-1:0] mem_q [0:DEPTH-1];  // Entry storage.
    logic [AW-1:0]    wr_q;               // Write index.
    logic [AW-1:0]    rd_q;               // Read index.
    logic [AW:0]      cnt_q;              // Entries held.

    wire do_wr = in_valid_i && in_ready_o;
    wire do_rd = out_valid_o && out_ready_i;

    assign in_ready_o  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid_o = (cnt_q != '0);
    assign out_data_o  = mem_q[rd_q];

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (do_wr) begin
                wr_q <= (wr_q == AW'(DEPTH-1)) ? '0 : AW'(wr_q + 1'b1);
            end
            if (do_rd) begin
                rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : AW'(rd_q + 1'b1);
            end
            cnt_q <= (AW+1)'(cnt_q + do_wr - do_rd);
        end
    end

    // Storage has no reset; empty entries are never presented.
    always_ff @(posedge clock_i) begin
        if (do_wr) begin
            mem_q[wr_q] <= in_data_i;
        end
    end

endmodule : mrc_buf2
`default_nettype wire

// ---- core/mrc_consts.svh ----
// Purpose: Constants of the serial read and relay force server.
// Assumes: One clock at 40 MHz; bytes arrive already deserialised.
// Notes:   Offsets, codes and timing figures live here only.
//
// What this block does
// - Function 01 returns relay on/off states.
// - At most 256 relays per status reply.
// - One relay per bit, off 0, on 1.
// - First relay in bit 0, ascending upward.
// - Unused upper bits of last byte are zero.
// - Byte count equals packed data bytes following.
// - Bytes go out least significant bit first; this block hands whole bytes to the shifter.
// - Function 02 returns inputs, at most 256.
// - Discrete inputs are numbered from zero.
// - Input reply packs first input in bit 0.
// - Function 03 returns holding registers from zero.
// - Register value sent high byte first.
// - Function 04 reads input registers, never written.
// - Function 05 drives one relay from zero.
// - FF00 switches relay on, 0000 switches off.
// - Other force values leave the relay unchanged.
// - Force reply echoes query after relay update.
// - Check starts all ones, shifts with constant.
// - Check bytes sent low byte first.
// - Silence of 3.5 characters discards partial frame.
// - Only frames for our address are answered.
`ifndef MRC_CONSTS_SVH
`define MRC_CONSTS_SVH

// Function codes served.
`define MRC_FN_READ_COILS  8'h01
`define MRC_FN_READ_INPUTS 8'h02
`define MRC_FN_READ_HOLD   8'h03
`define MRC_FN_READ_INREG  8'h04
`define MRC_FN_FORCE_COIL  8'h05

// Force data values.
`define MRC_FORCE_ON  16'hff00
`define MRC_FORCE_OFF 16'h0000

// Frame check seed, reflected constant and residue of a good frame.
`define MRC_CRC_INIT 16'hffff
`define MRC_CRC_POLY 16'ha001
`define MRC_CRC_GOOD 16'h0000

// Query layout: six kept field bytes, eight bytes in all.
`define MRC_FIELD_BYTES 3'd6
`define MRC_LAST_BYTE   3'd7

// Reply layout positions.
`define MRC_POS_BCOUNT   9'd2
`define MRC_POS_DATA     9'd3
`define MRC_HDR_READ     9'd3
`define MRC_HDR_FORCE    9'd2
`define MRC_ECHO_BYTES   9'd4

// Quantity limits per query.
`define MRC_MAX_BITS 16'h0100
`define MRC_MAX_REGS 16'h007f

// Timing: clock rate, character length and silence in tenths of a character.
`define MRC_CLK_HZ     40000000
`define MRC_BAUD       9600
`define MRC_CHAR_BITS  11
`define MRC_GAP_TENTHS 35

`endif

// ---- core/mrc_crc16.sv ----
// Purpose: One byte step of the 16-bit frame check.
// Assumes: Caller holds the running value in a register.
// Notes:   Purely combinational, eight shifts unrolled by a loop.
`include "mrc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mrc_crc16 (
    // Running value and byte.
    input  wire logic [15:0] crc_i,
    input  wire logic [7:0]  byte_i,
    // Value after the byte.
    output logic      [15:0] crc_o
);

    // Byte is folded in, then eight right shifts with conditional constant.
    always_comb begin
        logic [15:0] c;
        c = crc_i ^ {8'h00, byte_i};
        for (int i = 0; i < 8; i++) begin
            c = c[0] ? ((c >> 1) ^ `MRC_CRC_POLY) : (c >> 1);
        end
        crc_o = c;
    end

endmodule : mrc_crc16
`default_nettype wire

// ---- core/mrc_pkg.sv ----
// Purpose: Types shared by the server files.
// Assumes: Constants come from mrc_consts.svh.
// Notes:   One-hot state codes are written out.
package mrc_pkg;

    // Frame handler states.
    typedef enum logic [4:0] {
        ST_SKIP = 5'b00001,  // Waiting for line silence.
        ST_IDLE = 5'b00010,  // Next byte is an address.
        ST_RECV = 5'b00100,  // Collecting query bytes.
        ST_EXEC = 5'b01000,  // Checking and acting on the query.
        ST_SEND = 5'b10000   // Emitting the reply.
    } mrc_state_e;

    // One serial byte.
    typedef logic [7:0] mrc_byte_t;

endpackage : mrc_pkg

// ---- core/mrc_server.sv ----
// Purpose: Answers read status, read register and force relay queries.
// Assumes: A receiver delivers whole bytes and a transmitter shifts them out.
// Notes:   No exception replies; a query that cannot be served is dropped.
`include "mrc_consts.svh"
`timescale 1ns/10ps
`default_nettype none
module mrc_server
    import mrc_pkg::*;
#(
    parameter int          NUM_COILS  = 256,
    parameter int          NUM_INPUTS = 256,
    parameter int unsigned BAUD       = `MRC_BAUD,
    // Silence that ends a frame, rounded up to whole cycles.
    parameter int unsigned GAP_CYCLES = int'((64'd`MRC_GAP_TENTHS * `MRC_CHAR_BITS
        * `MRC_CLK_HZ + 64'd10 * BAUD - 64'd1) / (64'd10 * BAUD))
) (
    // Clock and reset.
    input  wire logic                  clock_i,
    input  wire logic                  rst_n_i,
    // Received bytes from the line receiver.
    input  wire logic                  rx_valid_i,
    input  wire logic [7:0]            rx_data_i,
    // Reply bytes to the line transmitter.
    output logic                       tx_valid_o,
    output logic      [7:0]            tx_data_o,
    input  wire logic                  tx_ready_i,
    // Own station address.
    input  wire logic [7:0]            own_addr_i,
    // Relay states and discrete input pins.
    output logic      [NUM_COILS-1:0]  coils_o,
    input  wire logic [NUM_INPUTS-1:0] din_i,
    // Register read port; data answers in the same cycle.
    output logic                       reg_kind_o,
    output logic      [15:0]           reg_addr_o,
    input  wire logic [15:0]           reg_data_i
);
    localparam int CW = (NUM_COILS > 1) ? $clog2(NUM_COILS) : 1;
    localparam int IW = (NUM_INPUTS > 1) ? $clog2(NUM_INPUTS) : 1;

    ////////////////////////////////////////////////////////////////////////////
    // State.
    ////////////////////////////////////////////////////////////////////////////

    mrc_state_e         st_q, st_d;       // Frame handler state.
    mrc_byte_t          frm_q [0:5];      // Address, function and four field bytes.
    logic [2:0]         cnt_q;            // Query bytes taken so far.
    logic [15:0]        crc_q;            // Running frame check.
    logic [31:0]        gap_q;            // Cycles since the last received byte.
    logic [8:0]         pos_q;            // Reply byte position.
    logic [15:0]        bit_addr_q;       // First item of the current data byte.
    logic [8:0]         rem_q;            // Status bits still to send.
    logic [15:0]        rd_addr_q;        // Register being sent.
    logic [NUM_COILS-1:0] coil_q;         // Relay storage.
    logic [NUM_INPUTS-1:0] din_s1_q;      // Input pins, first stage.
    logic [NUM_INPUTS-1:0] din_q;         // Input pins, settled.

    ////////////////////////////////////////////////////////////////////////////
    // Query decode.
    ////////////////////////////////////////////////////////////////////////////

    // Two-byte fields arrive high byte first.
    wire [7:0]  fn      = frm_q[1];
    wire [15:0] start   = {frm_q[2], frm_q[3]};
    wire [15:0] qty     = {frm_q[4], frm_q[5]};
    wire [CW-1:0] start_ix = start[CW-1:0];

    wire is_coils = (fn == `MRC_FN_READ_COILS);
    wire is_bits  = is_coils || (fn == `MRC_FN_READ_INPUTS);
    wire is_regs  = (fn == `MRC_FN_READ_HOLD) || (fn == `MRC_FN_READ_INREG);
    wire is_force = (fn == `MRC_FN_FORCE_COIL);

    // Quantity limits; a larger request gets no reply.
    wire bits_ok  = (qty != 16'h0000) && (qty <= `MRC_MAX_BITS);
    wire regs_ok  = (qty != 16'h0000) && (qty <= `MRC_MAX_REGS);
    wire force_on  = (qty == `MRC_FORCE_ON);
    wire force_off = (qty == `MRC_FORCE_OFF);
    wire force_ok  = (force_on || force_off)
                     && (start < 16'(NUM_COILS));

    wire addr_ok = (frm_q[0] == own_addr_i);
    wire crc_ok  = (crc_q == `MRC_CRC_GOOD);
    wire frame_ok = crc_ok && addr_ok && ((is_bits && bits_ok)
                    || (is_regs && regs_ok) || (is_force && force_ok));

    // Byte count: bits packed eight to a byte, registers two bytes each.
    wire [15:0] bc_bits = 16'(qty + 16'h0007) >> 3;
    wire [15:0] bc_regs = 16'(qty << 1);
    wire [7:0]  bcount  = is_bits ? bc_bits[7:0] : bc_regs[7:0];

    // Position of the low check byte; the high one follows it.
    wire [8:0] tot = is_force ? (`MRC_HDR_FORCE + `MRC_ECHO_BYTES)
                              : 9'(`MRC_HDR_READ + {1'b0, bcount});
    wire [8:0] dpos = 9'(pos_q - `MRC_POS_DATA);

    ////////////////////////////////////////////////////////////////////////////
    // Line timing and framing.
    ////////////////////////////////////////////////////////////////////////////

    wire gap_hit = (gap_q >= GAP_CYCLES);
    // A byte in ST_IDLE, or one after silence in ST_RECV, starts a fresh frame.
    wire frame_go = rx_valid_i && ((st_q == ST_IDLE)
                    || ((st_q == ST_RECV) && gap_hit));
    wire take = rx_valid_i && (st_q == ST_RECV) && !gap_hit;

    // Count silence; saturates so a quiet line stays marked as quiet.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_q <= 32'h0000_0000;
        end else if (rx_valid_i) begin
            gap_q <= 32'h0000_0000;
        end else if (!gap_hit) begin
            gap_q <= 32'(gap_q + 32'h0000_0001);
        end
    end

    // Input pins are asynchronous to this clock, so two stages first.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            din_s1_q <= '0;
            din_q    <= '0;
        end else begin
            din_s1_q <= din_i;
            din_q    <= din_s1_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Reply byte selection.
    ////////////////////////////////////////////////////////////////////////////

    // Each data bit: item numbered from zero, off as 0, on as 1, zero past the end.
    logic [7:0] bits_byte;
    for (genvar b = 0; b < 8; b++) begin : g_pack
        wire [15:0] item  = 16'(bit_addr_q + 16'(b));
        wire        c_in  = (item < 16'(NUM_COILS));
        wire        d_in  = (item < 16'(NUM_INPUTS));
        wire        c_val = c_in && coil_q[item[CW-1:0]];
        wire        d_val = d_in && din_q[item[IW-1:0]];
        assign bits_byte[b] = (9'(b) < rem_q)
                              && (is_coils ? c_val : d_val);
    end

    // Register bytes go high first, then low.
    wire [7:0] reg_byte  = dpos[0] ? reg_data_i[7:0] : reg_data_i[15:8];
    wire [7:0] data_byte = is_regs ? reg_byte : bits_byte;
    wire [7:0] echo_byte = frm_q[pos_q[2:0]];

    // Check bytes go low first.
    wire [7:0] crc_byte = (pos_q == tot) ? crc_q[7:0] : crc_q[15:8];
    wire [7:0] tx_byte =
        (pos_q == 9'd0)            ? own_addr_i :
        (pos_q == 9'd1)            ? fn :
        (pos_q >= tot)             ? crc_byte :
        is_force                   ? echo_byte :
        (pos_q == `MRC_POS_BCOUNT) ? bcount : data_byte;

    wire buf_ready;
    wire push      = (st_q == ST_SEND) && buf_ready;
    wire push_data = push && !is_force && (pos_q >= `MRC_POS_DATA) && (pos_q < tot);
    wire last_push = push && (pos_q == 9'(tot + 9'd1));

    // One check unit serves both directions; they never overlap.
    wire [15:0] crc_seed = frame_go ? `MRC_CRC_INIT : crc_q;
    wire [7:0]  crc_in   = (st_q == ST_SEND) ? tx_byte : rx_data_i;
    wire [15:0] crc_next;

    mrc_crc16 u_crc (
        .crc_i  (crc_seed),
        .byte_i (crc_in),
        .crc_o  (crc_next)
    );

    ////////////////////////////////////////////////////////////////////////////
    // State machine.
    ////////////////////////////////////////////////////////////////////////////

    // Next state: silence gates entry, eight bytes close the query.
    always_comb begin
        st_d = st_q;
        case (st_q)
            ST_SKIP: if (gap_hit) st_d = ST_IDLE;
            ST_IDLE: if (rx_valid_i) st_d = ST_RECV;
            ST_RECV: begin
                if (gap_hit && !rx_valid_i) begin
                    st_d = ST_IDLE;
                end else if (take && cnt_q == `MRC_LAST_BYTE) begin
                    st_d = ST_EXEC;
                end
            end
            ST_EXEC: st_d = frame_ok ? ST_SEND : ST_SKIP;
            ST_SEND: if (last_push) st_d = ST_SKIP;
            default: st_d = ST_SKIP;
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            st_q <= ST_SKIP;
        end else begin
            st_q <= st_d;
        end
    end

    // Query capture; the two check bytes only feed the check.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q <= 3'd0;
            for (int i = 0; i < 6; i++) frm_q[i] <= 8'h00;
        end else if (frame_go) begin
            frm_q[0] <= rx_data_i;
            cnt_q    <= 3'd1;
        end else if (take) begin
            if (cnt_q < `MRC_FIELD_BYTES) frm_q[cnt_q] <= rx_data_i;
            cnt_q <= 3'(cnt_q + 3'd1);
        end
    end

    // Check value: runs over the query, reseeded for the reply.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            crc_q <= `MRC_CRC_INIT;
        end else if (frame_go || take) begin
            crc_q <= crc_next;
        end else if (st_q == ST_EXEC) begin
            crc_q <= `MRC_CRC_INIT;
        end else if (push && pos_q < tot) begin
            crc_q <= crc_next;
        end
    end

    // Reply walk: position, status bit cursor and register cursor.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            pos_q      <= 9'd0;
            bit_addr_q <= 16'h0000;
            rem_q      <= 9'd0;
            rd_addr_q  <= 16'h0000;
        end else if (st_q == ST_EXEC) begin
            pos_q      <= 9'd0;
            bit_addr_q <= start;
            rem_q      <= qty[8:0];
            rd_addr_q  <= start;
        end else if (push) begin
            pos_q <= 9'(pos_q + 9'd1);
            if (push_data && is_bits) begin
                bit_addr_q <= 16'(bit_addr_q + 16'h0008);
                rem_q      <= (rem_q > 9'd8) ? 9'(rem_q - 9'd8) : 9'd0;
            end
            if (push_data && is_regs && dpos[0]) begin
                rd_addr_q <= 16'(rd_addr_q + 16'h0001);
            end
        end
    end

    // Relay force happens before the echo starts; bad values change nothing.
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            coil_q <= '0;
        end else if (st_q == ST_EXEC && frame_ok && is_force) begin
            coil_q[start_ix] <= force_on;
        end
    end

    assign coils_o    = coil_q;
    assign reg_addr_o = rd_addr_q;
    // Input registers are only read; this port has no write path.
    assign reg_kind_o = (fn == `MRC_FN_READ_INREG);

    ////////////////////////////////////////////////////////////////////////////
    // Output buffer; bytes leave whole for an LSB-first shifter.
    ////////////////////////////////////////////////////////////////////////////

    mrc_buf2 #(
        .WIDTH (8),
        .DEPTH (2)
    ) u_buf (
        .clock_i     (clock_i),
        .rst_n_i     (rst_n_i),
        .in_valid_i  (st_q == ST_SEND),
        .in_data_i   (tx_byte),
        .in_ready_o  (buf_ready),
        .out_valid_o (tx_valid_o),
        .out_data_o  (tx_data_o),
        .out_ready_i (tx_ready_i)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Assertions.
    ////////////////////////////////////////////////////////////////////////////

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_exec_ok;
        st_q == ST_EXEC && frame_ok;
    endsequence

    sequence s_exec_force;
        st_q == ST_EXEC && frame_ok && is_force;
    endsequence

    crc_seed_a: assert property (s_exec_ok |=> crc_q == `MRC_CRC_INIT && pos_q == 9'd0
        && st_q == ST_SEND) else $error("Reply check not seeded.");

    force_on_a: assert property (s_exec_force ##0 force_on |=> coil_q[$past(start_ix)]
        && st_q == ST_SEND) else $error("Relay not switched on.");

    force_bad_a: assert property (st_q == ST_EXEC && is_force && !force_on && !force_off
        |=> $stable(coil_q) && st_q == ST_SKIP) else $error("Bad force value acted on.");

    gap_flush_a: assert property (st_q == ST_RECV && gap_hit && !rx_valid_i
        |=> st_q == ST_IDLE) else $error("Partial frame not discarded.");

    addr_drop_a: assert property (st_q == ST_EXEC && !addr_ok
        |=> st_q == ST_SKIP ##1 st_q != ST_SEND) else $error("Foreign frame answered.");

    crc_order_a: assert property (push && pos_q == tot |-> tx_byte == crc_q[7:0]
        ##1 $stable(crc_q)) else $error("Check bytes out of order.");

    bcount_a: assert property (push && !is_force && pos_q == `MRC_POS_BCOUNT
        |-> tx_byte == bcount) else $error("Byte count wrong.");

    pad_zero_a: assert property (push_data && is_bits && rem_q < 9'd8
        |-> (tx_byte >> rem_q[3:0]) == 8'h00) else $error("Padding bits not zero.");

    reg_high_a: assert property (push_data && is_regs && !dpos[0]
        |-> tx_byte == reg_data_i[15:8] ##1 !push || tx_byte == reg_data_i[7:0])
        else $error("Register byte order wrong.");

    echo_a: assert property (push && is_force && pos_q >= 9'd2 && pos_q < tot
        |-> tx_byte == frm_q[pos_q[2:0]]) else $error("Force echo differs.");

endmodule : mrc_server
`default_nettype wire

// ---- tb/mrc_client.sv ----
// Purpose: Client model that sends queries and collects replies.
// Assumes: Bytes are already deserialised; one clock.
// Notes:   Stalls the reply stream at random to exercise the buffer.
`timescale 1ns/10ps
`default_nettype none
module mrc_client
    import mrc_pkg::*;
(
    // Clock.
    input  wire logic       clock_i,
    // Query stream.
    output logic            rx_valid_o,
    output logic      [7:0] rx_data_o,
    // Reply stream.
    input  wire logic       tx_valid_i,
    input  wire logic [7:0] tx_data_i,
    output logic            tx_ready_o
);
    mrc_byte_t rq[$];               // Reply bytes taken so far.
    int        seed = 32'hfc3b202b; // Fixed seed, so stalls repeat.
    initial begin
        rx_valid_o = 1'b0;
        rx_data_o  = 8'h00;
        tx_ready_o = 1'b0;
    end
    // Take an offered byte, then stall one cycle in four.
    always @(posedge clock_i) begin
        if (tx_valid_i && tx_ready_o) rq.push_back(tx_data_i);
        tx_ready_o <= ($random(seed) & 3) != 0;
    end
    // Frame check: all ones seed, reflected constant.
    function automatic logic [15:0] crc(input mrc_byte_t b[$]);
        logic [15:0] c;
        c = 16'hffff;
        foreach (b[i]) begin
            c = c ^ {8'h00, b[i]};
            for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'ha001 : c >> 1;
        end
        return c;
    endfunction : crc
    // Send fields back to back, check low byte first; good=0 spoils it.
    task automatic send(input mrc_byte_t b[$], input logic good);
        logic [15:0] c;
        c = crc(b) ^ {15'h0, !good};
        b.push_back(c[7:0]);
        b.push_back(c[15:8]);
        foreach (b[i]) begin
            @(posedge clock_i);
            rx_valid_o <= 1'b1;
            rx_data_o  <= b[i];
        end
        @(posedge clock_i);
        rx_valid_o <= 1'b0;
        rx_data_o  <= ~rx_data_o; // A released line shows no stale byte.
    endtask : send
endmodule : mrc_client
`default_nettype wire

// ---- tb/mrc_server_test.sv ----
// Purpose: Self-checking bench of the read and relay force server.
// Assumes: Station address 11; short silence and 32 relays and inputs.
// Notes:   Expected replies are rebuilt here from the query fields.
`timescale 1ns/10ps
`default_nettype none
module mrc_server_test
    import mrc_pkg::*;
;
    localparam int NC = 32;
    localparam int GAP = 20;
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic rx_valid, tx_valid, tx_ready, reg_kind;
    logic [7:0] rx_data, tx_data;
    logic [NC-1:0] coils, cm;
    logic [NC-1:0] din = '0;
    logic [15:0] reg_addr, reg_data;
    mrc_byte_t ex[$];  // Reply expected, empty when none is due.
    int num_errors = 0;
    int cmp_count = 0;
    int cycles = 0;
    int seed = 32'hfc3b202b;
    initial forever #12.5 clock_i = ~clock_i;
    // Register storage; holding and input registers differ.
    function automatic logic [15:0] regval(input logic k, input logic [15:0] a);
        return {a[7:0] ^ (k ? 8'h4c : 8'h7a), ~a[15:8]};
    endfunction : regval
    assign reg_data = regval(reg_kind, reg_addr);
    mrc_server #(.NUM_COILS(NC), .NUM_INPUTS(NC), .GAP_CYCLES(GAP)) dut (
        .clock_i(clock_i), .rst_n_i(rst_n_i), .rx_valid_i(rx_valid),
        .rx_data_i(rx_data), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .tx_ready_i(tx_ready), .own_addr_i(8'h11), .coils_o(coils),
        .din_i(din), .reg_kind_o(reg_kind), .reg_addr_o(reg_addr),
        .reg_data_i(reg_data));
    mrc_client cl (
        .clock_i(clock_i), .rx_valid_o(rx_valid), .rx_data_o(rx_data),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_ready_o(tx_ready));
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_of_test
    // A hang counts as a mismatch.
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == 60000) begin
            num_errors++;
            end_of_test();
        end
    end
    // Read reply: header, byte count, packed bits or registers.
    function automatic void build(mrc_byte_t fn, logic [15:0] st, logic [15:0] qn);
        mrc_byte_t b;
        logic [15:0] r;
        int a;
        b = 8'h00;
        ex = {8'h11, fn, (fn > 8'h02) ? 8'(qn * 2) : 8'((qn + 7) / 8)};
        for (int i = 0; i < qn; i++) begin
            a = st + i;
            r = regval(fn[2], 16'(a));
            if (fn > 8'h02) begin
                ex.push_back(r[15:8]);
                ex.push_back(r[7:0]);
            end else begin
                b[i % 8] = (a < NC) ? (fn == 8'h01 ? cm[a] : din[a]) : 1'b0;
                if (i % 8 == 7 || i == qn - 1) begin
                    ex.push_back(b);
                    b = 8'h00;
                end
            end
        end
    endfunction : build
    // Send one query, then compare the whole reply and the relays.
    task automatic run(input mrc_byte_t q[$], input logic good);
        logic [15:0] c;
        logic bad;
        int n;
        if (ex.size() != 0) begin
            c = cl.crc(ex);
            ex.push_back(c[7:0]);
            ex.push_back(c[15:8]);
        end
        cl.rq.delete();
        cl.send(q, good);
        n = 0;
        while (cl.rq.size() < ex.size() && n < 1000) begin
            @(posedge clock_i);
            n++;
        end
        repeat (60) @(posedge clock_i);
        cmp_count++;
        bad = cl.rq.size() != ex.size() || coils !== cm;
        foreach (ex[i]) if (i < cl.rq.size() && cl.rq[i] !== ex[i]) bad = 1'b1;
        if (bad) begin
            num_errors++;
            $display("CHECK FAILED t=%0t fn %h reply or relays differ", $time, q[1]);
        end
    endtask : run
    initial begin
        static logic [15:0] fv[6] = '{16'hff00, 16'h0000, 16'hff00,
                                      16'h00ff, 16'hff01, 16'hff00};
        static mrc_byte_t cfn[3] = '{8'h01, 8'h02, 8'h03};
        static logic [15:0] cqn[3] = '{16'd256, 16'd257, 16'd127};
        logic [15:0] st, qn, v;
        mrc_byte_t fn;
        mrc_byte_t q[$];  // Force query as sent; the reply is only due when valid.
        logic ok;
        cm = '0;
        repeat (20) @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (GAP + 2) @(posedge clock_i);
        // Forces: a table of fixed values, some invalid and one to a foreign address, first, then random on and off.
        for (int k = 0; k < 16; k++) begin
            st = 16'($random(seed) & (NC - 1));
            v = (k < 6) ? fv[k] : ($random(seed) & 1) ? 16'hff00 : 16'h0000;
            ok = (v == 16'hff00 || v == 16'h0000) && k != 5;
            if (ok) cm[st[4:0]] = v[15];
            q = {k == 5 ? 8'h12 : 8'h11, 8'h05, st[15:8], st[7:0], v[15:8], v[7:0]};
            ex = q;
            if (!ok) ex.delete();
            run(q, 1'b1);
        end
        // A partial frame must be dropped after silence.
        cl.rq.delete();
        cl.send({8'h11, 8'h03}, 1'b1);
        repeat (GAP + 2) @(posedge clock_i);
        cmp_count++;
        if (cl.rq.size() != 0) begin
            num_errors++;
            $display("CHECK FAILED t=%0t partial frame answered", $time);
        end
        // Reads: corner quantities, then random function, start and count.
        for (int k = 0; k < 28; k++) begin
            fn = (k < 3) ? cfn[k] : 8'(1 + ($random(seed) & 3));
            st = (fn < 8'h03) ? 16'($random(seed) & 63) : 16'($random(seed));
            qn = (k < 3) ? cqn[k] : 16'(1 + ($random(seed) & (fn < 8'h03 ? 47 : 7)));
            din <= NC'($random(seed));
            @(posedge clock_i);
            ok = qn <= (fn < 8'h03 ? 16'd256 : 16'd127) && k != 3;
            ex.delete();
            if (ok) build(fn, st, qn);
            run({8'h11, fn, st[15:8], st[7:0], qn[15:8], qn[7:0]}, k != 3);
        end
        end_of_test();
    end
endmodule : mrc_server_test
`default_nettype wire
